// File: rtl/icr_addr_match.sv
// Combinational own-address comparison for a received slave address.
// Assumes the caller registers the result; inputs are stable in one cycle.
`timescale 1ns/1ps
module icr_addr_match (
	input  wire logic       width_select_in,
	input  wire logic [9:0] own_address_in,
	input  wire logic       dual_match_enable_in,
	input  wire logic [6:0] second_slave_address_in,
	input  wire logic       probe_valid_in,
	input  wire logic       probe_is_ten_in,
	input  wire logic [9:0] probe_address_in,
	output logic            hit_out
);

	logic ten_hit;
	logic seven_hit;

	// Ten-bit mode compares all ten bits and refuses seven-bit probes.
	// width select gating
	assign ten_hit = width_select_in && probe_is_ten_in &&
		(probe_address_in == own_address_in);

	// Seven-bit mode looks at bits 7:1 only; the secondary joins if enabled.
	// secondary address compare
	assign seven_hit = !width_select_in && !probe_is_ten_in &&
		((probe_address_in[6:0] == own_address_in[7:1]) ||
		(dual_match_enable_in &&
		(probe_address_in[6:0] == second_slave_address_in)));

	assign hit_out = probe_valid_in && (ten_hit || seven_hit);

endmodule : icr_addr_match

// File: rtl/icr_irq_gen.sv
// Combinational interrupt and DMA request terms from flags and enables.
// Assumes flags are levels held by the bus engine until cleared.
`timescale 1ns/1ps
module icr_irq_gen (
	input  wire logic              dma_request_enable_in,
	input  wire logic              buffer_irq_enable_in,
	input  wire logic              event_irq_enable_in,
	input  wire logic              error_irq_enable_in,
	input  wire icr_pkg::icr_flags_t flags_in,
	input  wire icr_pkg::icr_errs_t  errs_in,
	output logic                   event_irq_out,
	output logic                   error_irq_out,
	output logic                   dma_request_out
);

	logic buf_flag;
	logic evt_flag;

	assign buf_flag = flags_in.transmit_empty_flag ||
		flags_in.receive_full_flag;

	// Master-only and slave-only events are qualified by the mode bit.
	// event sources
	assign evt_flag = (flags_in.start_sent_flag && flags_in.master_mode) ||
		flags_in.address_flag ||
		(flags_in.ten_bit_header_flag && flags_in.master_mode) ||
		(flags_in.stop_seen_flag && !flags_in.master_mode) ||
		flags_in.byte_finished_flag;

	assign event_irq_out = (event_irq_enable_in && evt_flag) ||
		(buffer_irq_enable_in && buf_flag);

	assign error_irq_out = error_irq_enable_in && (|errs_in);

	assign dma_request_out = dma_request_enable_in && buf_flag;

endmodule : icr_irq_gen

// File: rtl/icr_pkg.sv
// Constants and carriers shared by the two-wire controller register block.
// Assumes a 16-bit register port with byte addresses on an 8-bit bus.
package icr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses.
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 16;
	localparam logic [7:0]  OFS_CONTROL   = 8'h04;
	localparam logic [7:0]  OFS_OWN_PRI   = 8'h08;
	localparam logic [7:0]  OFS_OWN_SEC   = 8'h0C;
	localparam logic [7:0]  OFS_BYTE_BUF  = 8'h10;

	////////////////////////////////////////////////////////////////////////
	// Control register two field positions.
	localparam int          CTL_LAST      = 12;
	localparam int          CTL_DMA_EN    = 11;
	localparam int          CTL_BUF_IE    = 10;
	localparam int          CTL_EVT_IE    = 9;
	localparam int          CTL_ERR_IE    = 8;
	localparam int          CTL_MHZ_LSB   = 0;
	localparam int          MHZ_W         = 6;

	// Own address register fields.
	localparam int          OWN_MODE      = 15;
	localparam int          OWN_ADDR_W    = 10;
	localparam int          SEC_ADDR_LSB  = 1;
	localparam int          SEC_ADDR_W    = 7;
	localparam int          SEC_DUAL      = 0;
	localparam int          BYTE_W        = 8;

	// Reset values.
	localparam logic [15:0] RST_CONTROL   = 16'h0000;
	localparam logic [15:0] RST_OWN       = 16'h0000;
	localparam logic [7:0]  RST_BYTE      = 8'h00;

	// Legal module clock range in MHz.
	localparam logic [5:0]  MHZ_MIN       = 6'h08;
	localparam logic [5:0]  MHZ_MAX       = 6'h30;

	////////////////////////////////////////////////////////////////////////
	// Register port selector.
	typedef enum {
		ICR_SEL_NONE,
		ICR_SEL_CONTROL,
		ICR_SEL_OWN_PRI,
		ICR_SEL_OWN_SEC,
		ICR_SEL_BYTE
	} icr_sel_t;

	// Event flags reported by the bus engine.
	typedef struct packed {
		logic master_mode;
		logic start_sent_flag;
		logic address_flag;
		logic ten_bit_header_flag;
		logic stop_seen_flag;
		logic byte_finished_flag;
		logic transmit_empty_flag;
		logic receive_full_flag;
	} icr_flags_t;

	// Error flags reported by the bus engine.
	typedef struct packed {
		logic bus_error_flag;
		logic arbitration_lost_flag;
		logic ack_failure_flag;
		logic overrun_flag;
		logic packet_check_error_flag;
		logic timeout_flag;
		logic bus_alert_flag;
	} icr_errs_t;

endpackage : icr_pkg

// File: rtl/icr_regs.sv
// Register block of a two-wire controller: control two, own addresses and
// the byte buffer, with interrupt, DMA and address-match outputs.
// Assumes a bus engine that reports flags as levels and bytes as pulses.
//
// How it works
// - Last bit set makes the next DMA end-of-transfer final.
// - Master receiver uses the final mark to NACK the last byte.
// - DMA enable raises a request while transmit-empty or receive-full.
// - Buffer enable turns transmit-empty or receive-full into interrupts.
// - Event enable interrupts on master start and header, address, slave stop, byte done.
// - Error enable interrupts on any of the seven error flags.
// - Width select picks ten-bit or seven-bit matching exclusively.
// - Ten-bit compares bits 9:0; seven-bit compares bits 7:1 only.
// - Dual enable adds the secondary seven-bit address in seven-bit mode.
// - Byte buffer holds received or software bytes; upper bits zero.
`timescale 1ns/1ps
module icr_regs (
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic [7:0]        reg_addr_in,
	input  wire logic [15:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [15:0]       reg_rdata_out,
	input  wire icr_pkg::icr_flags_t flags_in,
	input  wire icr_pkg::icr_errs_t  errs_in,
	input  wire logic              master_rx_in,
	input  wire logic              dma_end_of_transfer_in,
	input  wire logic              rx_valid_in,
	input  wire logic [7:0]        rx_byte_in,
	input  wire logic              probe_valid_in,
	input  wire logic              probe_is_ten_in,
	input  wire logic [9:0]        probe_address_in,
	output logic [7:0]             tx_byte_out,
	output logic                   tx_load_out,
	output logic                   buf_read_out,
	output logic                   dma_request_out,
	output logic                   event_irq_out,
	output logic                   error_irq_out,
	output logic                   final_transfer_out,
	output logic                   nack_last_out,
	output logic                   address_hit_out,
	output logic [5:0]             module_clock_mhz_out,
	output logic                   clock_in_range_out
);
	// Every check below runs on the core clock and sleeps during reset.
	default clocking check_cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////////////////////////////////////
	// Address decode shared by the read and write paths.
	function automatic icr_pkg::icr_sel_t sel_of(input logic [7:0] a);
		if (a == icr_pkg::OFS_CONTROL) begin
			return icr_pkg::ICR_SEL_CONTROL;
		end else if (a == icr_pkg::OFS_OWN_PRI) begin
			return icr_pkg::ICR_SEL_OWN_PRI;
		end else if (a == icr_pkg::OFS_OWN_SEC) begin
			return icr_pkg::ICR_SEL_OWN_SEC;
		end else if (a == icr_pkg::OFS_BYTE_BUF) begin
			return icr_pkg::ICR_SEL_BYTE;
		end else begin
			return icr_pkg::ICR_SEL_NONE;
		end
	endfunction : sel_of

	icr_pkg::icr_sel_t sel;
	logic              wr_ctl;
	logic              wr_pri;
	logic              wr_sec;
	logic              wr_buf;
	logic              rd_buf;

	assign sel    = sel_of(reg_addr_in);
	assign wr_ctl = reg_wr_in && (sel == icr_pkg::ICR_SEL_CONTROL);
	assign wr_pri = reg_wr_in && (sel == icr_pkg::ICR_SEL_OWN_PRI);
	assign wr_sec = reg_wr_in && (sel == icr_pkg::ICR_SEL_OWN_SEC);
	assign wr_buf = reg_wr_in && (sel == icr_pkg::ICR_SEL_BYTE);
	assign rd_buf = reg_rd_in && (sel == icr_pkg::ICR_SEL_BYTE);

	////////////////////////////////////////////////////////////////////////
	// Control register two fields.
	logic       last_r;
	logic       dma_en_r;
	logic       buf_ie_r;
	logic       evt_ie_r;
	logic       err_ie_r;
	logic [5:0] mhz_r;

	// Only the defined fields are stored, so reserved bits drop writes.
	// reserved write drop
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_r   <= icr_pkg::RST_CONTROL[icr_pkg::CTL_LAST];
			dma_en_r <= icr_pkg::RST_CONTROL[icr_pkg::CTL_DMA_EN];
			buf_ie_r <= icr_pkg::RST_CONTROL[icr_pkg::CTL_BUF_IE];
			evt_ie_r <= icr_pkg::RST_CONTROL[icr_pkg::CTL_EVT_IE];
			err_ie_r <= icr_pkg::RST_CONTROL[icr_pkg::CTL_ERR_IE];
			mhz_r    <= icr_pkg::RST_CONTROL[5:0];
		end else if (wr_ctl) begin
			last_r   <= reg_wdata_in[icr_pkg::CTL_LAST];
			dma_en_r <= reg_wdata_in[icr_pkg::CTL_DMA_EN];
			buf_ie_r <= reg_wdata_in[icr_pkg::CTL_BUF_IE];
			evt_ie_r <= reg_wdata_in[icr_pkg::CTL_EVT_IE];
			err_ie_r <= reg_wdata_in[icr_pkg::CTL_ERR_IE];
			mhz_r    <= reg_wdata_in[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Own address registers.
	logic       width_sel_r;
	logic [9:0] own_addr_r;
	logic [6:0] sec_addr_r;
	logic       dual_en_r;

	// Primary own address: mode bit plus ten address bits.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			width_sel_r <= icr_pkg::RST_OWN[icr_pkg::OWN_MODE];
			own_addr_r  <= icr_pkg::RST_OWN[9:0];
		end else if (wr_pri) begin
			width_sel_r <= reg_wdata_in[icr_pkg::OWN_MODE];
			own_addr_r  <= reg_wdata_in[9:0];
		end
	end

	// Secondary own address and its dual enable.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sec_addr_r <= icr_pkg::RST_OWN[7:1];
			dual_en_r  <= icr_pkg::RST_OWN[icr_pkg::SEC_DUAL];
		end else if (wr_sec) begin
			sec_addr_r <= reg_wdata_in[7:1];
			dual_en_r  <= reg_wdata_in[icr_pkg::SEC_DUAL];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte buffer. A received byte wins over a software write in the same
	// cycle, because losing bus data is worse than redoing a write.
	logic [7:0] buf_r;
	logic [7:0] buf_nxt;

	always_comb begin
		buf_nxt = buf_r;
		if (rx_valid_in) begin
			buf_nxt = rx_byte_in;
		end else if (wr_buf) begin
			buf_nxt = reg_wdata_in[7:0];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_r <= icr_pkg::RST_BYTE;
		end else begin
			buf_r <= buf_nxt;
		end
	end

	// Transmit byte and access pulses toward the bus engine's flag logic.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_byte_out  <= icr_pkg::RST_BYTE;
			tx_load_out  <= 1'b0;
			buf_read_out <= 1'b0;
		end else begin
			tx_byte_out  <= buf_nxt;
			tx_load_out  <= wr_buf && !rx_valid_in;
			buf_read_out <= rd_buf;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after the strobe.
	logic [15:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 16'h0000;
		if (reg_rd_in) begin
			if (sel == icr_pkg::ICR_SEL_CONTROL) begin
				rdata_nxt[icr_pkg::CTL_LAST]   = last_r;
				rdata_nxt[icr_pkg::CTL_DMA_EN] = dma_en_r;
				rdata_nxt[icr_pkg::CTL_BUF_IE] = buf_ie_r;
				rdata_nxt[icr_pkg::CTL_EVT_IE] = evt_ie_r;
				rdata_nxt[icr_pkg::CTL_ERR_IE] = err_ie_r;
				rdata_nxt[5:0]                 = mhz_r;
			end else if (sel == icr_pkg::ICR_SEL_OWN_PRI) begin
				rdata_nxt[icr_pkg::OWN_MODE] = width_sel_r;
				rdata_nxt[9:0]               = own_addr_r;
			end else if (sel == icr_pkg::ICR_SEL_OWN_SEC) begin
				rdata_nxt[7:1]               = sec_addr_r;
				rdata_nxt[icr_pkg::SEC_DUAL] = dual_en_r;
			end else if (sel == icr_pkg::ICR_SEL_BYTE) begin
				rdata_nxt[7:0] = buf_r;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 16'h0000;
		end else begin
			reg_rdata_out <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt and DMA terms, registered so outputs come from flops.
	logic evt_c;
	logic err_c;
	logic dma_c;

	icr_irq_gen u_irq (
		.dma_request_enable_in (dma_en_r),
		.buffer_irq_enable_in  (buf_ie_r),
		.event_irq_enable_in   (evt_ie_r),
		.error_irq_enable_in   (err_ie_r),
		.flags_in              (flags_in),
		.errs_in               (errs_in),
		.event_irq_out         (evt_c),
		.error_irq_out         (err_c),
		.dma_request_out       (dma_c)
	);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			event_irq_out   <= 1'b0;
			error_irq_out   <= 1'b0;
			dma_request_out <= 1'b0;
		end else begin
			event_irq_out   <= evt_c;
			error_irq_out   <= err_c;
			dma_request_out <= dma_c;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Final-transfer tracking. The mark is set by an end-of-transfer while
	// the last bit is set and held until the next received byte consumes
	// it; a set in the same cycle as that byte wins.
	logic final_r;
	logic final_nxt;

	always_comb begin
		final_nxt = final_r;
		if (dma_end_of_transfer_in && last_r) begin
			final_nxt = 1'b1;
		end else if (rx_valid_in) begin
			final_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			final_r <= 1'b0;
		end else begin
			final_r <= final_nxt;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			final_transfer_out <= 1'b0;
			nack_last_out      <= 1'b0;
		end else begin
			final_transfer_out <= dma_end_of_transfer_in && last_r;
			nack_last_out      <= final_nxt && master_rx_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address matching on a probe from the bus engine.
	logic hit_c;

	icr_addr_match u_match (
		.width_select_in         (width_sel_r),
		.own_address_in          (own_addr_r),
		.dual_match_enable_in    (dual_en_r),
		.second_slave_address_in (sec_addr_r),
		.probe_valid_in          (probe_valid_in),
		.probe_is_ten_in         (probe_is_ten_in),
		.probe_address_in        (probe_address_in),
		.hit_out                 (hit_c)
	);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			address_hit_out <= 1'b0;
		end else begin
			address_hit_out <= hit_c;
		end
	end

	// Clock field out, with a range flag; the range is not enforced.
	// clock range indication
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			module_clock_mhz_out <= 6'h00;
			clock_in_range_out   <= 1'b0;
		end else begin
			module_clock_mhz_out <= mhz_r;
			clock_in_range_out   <= (mhz_r >= icr_pkg::MHZ_MIN) &&
				(mhz_r <= icr_pkg::MHZ_MAX);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions, on the default clock with reset as the disable.
	a_dma_req_follow: assert property (
		dma_en_r && flags_in.receive_full_flag |=> dma_request_out)
		else $error("DMA request missing while receive full");
	a_dma_req_off: assert property (
		!dma_en_r |=> !dma_request_out)
		else $error("DMA request while disabled");
	a_evt_buf_irq: assert property (
		buf_ie_r && flags_in.transmit_empty_flag |=> event_irq_out)
		else $error("Buffer event interrupt missing");
	a_evt_irq_quiet: assert property (
		!evt_ie_r && !buf_ie_r |=> !event_irq_out)
		else $error("Event interrupt while disabled");
	a_err_irq_set: assert property (
		err_ie_r && errs_in.timeout_flag |=> error_irq_out)
		else $error("Error interrupt missing on timeout");
	a_err_irq_off: assert property (
		!err_ie_r |=> !error_irq_out)
		else $error("Error interrupt while disabled");
	a_rd_buf_data: assert property (
		rd_buf |=> reg_rdata_out == {8'h00, $past(buf_r)})
		else $error("Byte buffer read data wrong");
	a_rd_unmapped_zero: assert property (
		reg_rd_in && sel == icr_pkg::ICR_SEL_NONE
		|=> reg_rdata_out == 16'h0000)
		else $error("Unmapped read not zero");
	a_final_nack: assert property (
		dma_end_of_transfer_in && last_r && master_rx_in
		|=> nack_last_out && final_transfer_out)
		else $error("Final NACK not raised");
	a_no_final_clear: assert property (
		dma_end_of_transfer_in && !last_r |=> !final_transfer_out)
		else $error("Final marked with last bit clear");
	a_ten_reject: assert property (
		probe_valid_in && probe_is_ten_in && !width_sel_r
		|=> !address_hit_out)
		else $error("Ten-bit probe matched in seven-bit mode");
	a_seven_match: assert property (
		probe_valid_in && !probe_is_ten_in && !width_sel_r &&
		probe_address_in[6:0] == own_addr_r[7:1] |=> address_hit_out)
		else $error("Seven-bit own address not matched");
	a_dual_match: assert property (
		probe_valid_in && !probe_is_ten_in && !width_sel_r && dual_en_r &&
		probe_address_in[6:0] == sec_addr_r |=> address_hit_out)
		else $error("Secondary address not matched");

endmodule : icr_regs

// File: verification/icr_peer_model.sv
// Far-side model: a bus peer that hands in received bytes and addresses.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module icr_peer_model (
	input  wire logic clk_in,
	output logic       rx_valid_out,
	output logic [7:0] rx_byte_out,
	output logic       probe_valid_out,
	output logic       probe_is_ten_out,
	output logic [9:0] probe_address_out
);
	////////////////////////////////////////////////////////////////////////
	// Lines start quiet; after each use they carry the inverse value so a
	// design that samples stale data cannot pass by luck.
	initial begin
		rx_valid_out      = 1'b0;
		rx_byte_out       = 8'h00;
		probe_valid_out   = 1'b0;
		probe_is_ten_out  = 1'b0;
		probe_address_out = 10'h000;
	end

	// One received byte after a gap, so the peer can be prompt or slow.
	task automatic send_byte(input logic [7:0] b, input int gap);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		rx_valid_out <= 1'b1;
		rx_byte_out  <= b;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_byte_out  <= ~b;
	endtask : send_byte

	// One address seen on the wire, seven or ten bits wide.
	task automatic send_addr(input logic t, input logic [9:0] a, input int gap);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		probe_valid_out   <= 1'b1;
		probe_is_ten_out  <= t;
		probe_address_out <= a;
		@(posedge clk_in);
		probe_valid_out   <= 1'b0;
		probe_is_ten_out  <= ~t;
		probe_address_out <= ~a;
	endtask : send_addr
endmodule : icr_peer_model

// File: verification/test_icr_regs.sv
// Self-checking bench for the register block against a reference model.
// Assumes the design package and the peer model are compiled first.
`timescale 1ns/1ps
module test_icr_regs;
	logic                clk   = 1'b0;
	logic                rst_n = 1'b0;
	logic [7:0]          addr  = 8'h00;
	logic [15:0]         wdata = 16'h0000;
	logic                wr_s  = 1'b0;
	logic                rd_s  = 1'b0;
	icr_pkg::icr_flags_t flags = '0;
	icr_pkg::icr_errs_t  errs  = '0;
	logic                mrx   = 1'b0;
	logic                dma_end_of_transfer   = 1'b0;
	logic                rxv, pv, pten, txl, bufr, dma, evt, err;
	logic                fin, nack, hit, rng;
	logic [7:0]          rxb, txb;
	logic [9:0]          pa;
	logic [5:0]          mhz;
	logic [15:0]         rdata, v, p, s;
	logic [15:0]         m [4];
	logic [7:0]          ofs [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h00, 8'h14};
	logic [15:0]         msk [4] = '{16'h1F3F, 16'h83FF, 16'h00FF, 16'h00FF};
	logic [5:0]          bnd [4] = '{6'h07, 6'h08, 6'h30, 6'h31};
	int                  n_mismatch = 0;
	int                  n_tests = 0;

	always #2.5 clk = ~clk;

	icr_regs dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .flags_in(flags), .errs_in(errs),
		.master_rx_in(mrx), .dma_end_of_transfer_in(dma_end_of_transfer), .rx_valid_in(rxv),
		.rx_byte_in(rxb), .probe_valid_in(pv), .probe_is_ten_in(pten),
		.probe_address_in(pa), .tx_byte_out(txb), .tx_load_out(txl),
		.buf_read_out(bufr), .dma_request_out(dma), .event_irq_out(evt),
		.error_irq_out(err), .final_transfer_out(fin), .nack_last_out(nack),
		.address_hit_out(hit), .module_clock_mhz_out(mhz),
		.clock_in_range_out(rng));

	icr_peer_model peer_u (.clk_in(clk), .rx_valid_out(rxv),
		.rx_byte_out(rxb), .probe_valid_out(pv), .probe_is_ten_out(pten),
		.probe_address_out(pa));

	////////////////////////////////////////////////////////////////////////
	// Compare and count; four-state equality keeps unknowns from matching.
	task automatic chk(input string nm, input logic [15:0] got, e);
		n_tests++;
		if (got !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, got);
		end
	endtask : chk

	task automatic results();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// Bus write; the model follows and the buffer strobe is checked.
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr_s  <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
		for (int k = 0; k < 4; k++) begin
			if (a == ofs[k]) begin
				m[k] = d & msk[k];
			end
		end
		chk("tx_load", txl, a == 8'h10);
		if (a == 8'h10) begin
			chk("tx_byte", txb, d[7:0]);
		end
	endtask : bus_wr

	// Bus read; data stand only in the cycle after the strobe.
	task automatic bus_rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("rdata", rdata, e);
		chk("buf_read", bufr, a == 8'h10);
	endtask : bus_rd

	// Hang guard: a run that overstays is a mismatch.
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic t;
		logic [9:0] a;
		logic x;
		void'($urandom(32'h2ed39556));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
		foreach (ofs[i]) bus_rd(ofs[i], 16'h0000);
		// Random writes; reserved bits and unmapped places stay zero.
		for (int i = 0; i < 48; i++) begin
			v = 16'($urandom);
			if (i % 6 == 0) v[5:0] = bnd[(i / 6) % 4];
			bus_wr(ofs[i % 6], v);
			bus_rd(ofs[i % 6], (i % 6 < 4) ? m[i % 6] : 16'h0000);
			chk("mhz", mhz, m[0][5:0]);
			chk("range", rng, m[0][5:0] >= 8 && m[0][5:0] <= 48);
		end
		// Enables against random flag and error levels.
		for (int i = 0; i < 60; i++) begin
			bus_wr(8'h04, 16'($urandom) & 16'h0F3F);
			@(posedge clk);
			flags <= 8'($urandom);
			errs  <= 7'($urandom);
			@(posedge clk);
			#1;
			x = flags.transmit_empty_flag | flags.receive_full_flag;
			chk("dma", dma, m[0][11] & x);
			chk("evt", evt, (m[0][10] & x) | (m[0][9] & ((flags.master_mode
				& (flags.start_sent_flag | flags.ten_bit_header_flag))
				| flags.address_flag | flags.byte_finished_flag
				| (flags.stop_seen_flag & ~flags.master_mode))));
			chk("err", err, m[0][8] & (|errs));
		end
		// Final transfer marking, then the received byte clears it.
		bus_wr(8'h04, 16'h1010);
		@(posedge clk);
		mrx <= 1'b1;
		dma_end_of_transfer <= 1'b1;
		@(posedge clk);
		dma_end_of_transfer <= 1'b0;
		#1;
		chk("final", fin, 1'b1);
		chk("nack", nack, 1'b1);
		@(posedge clk);
		#1;
		chk("final", fin, 1'b0);
		chk("nack", nack, 1'b1);
		v = 16'($urandom);
		peer_u.send_byte(v[7:0], 3);
		#1;
		m[3] = {8'h00, v[7:0]};
		chk("nack", nack, 1'b0);
		bus_rd(8'h10, m[3]);
		bus_wr(8'h04, 16'h0010);
		@(posedge clk);
		dma_end_of_transfer <= 1'b1;
		@(posedge clk);
		dma_end_of_transfer <= 1'b0;
		mrx <= 1'b0;
		#1;
		chk("final", fin, 1'b0);
		chk("nack", nack, 1'b0);
		// Address matching over both widths and the second address.
		for (int i = 0; i < 80; i++) begin
			t = 1'($urandom);
			p = 16'($urandom);
			s = 16'($urandom);
			a = 10'($urandom);
			if (i % 2) p[15] = t;
			bus_wr(8'h08, p);
			bus_wr(8'h0C, s);
			if (i % 2) a = t ? p[9:0] : {3'h0, (i % 4 == 1) ? s[7:1] : p[7:1]};
			if (!t) a[9:7] = 3'h0;
			peer_u.send_addr(t, a, i % 3);
			#1;
			chk("hit", hit, (p[15] == t) && (t ? a == p[9:0] : (a[6:0] == p[7:1]
				|| (s[0] && a[6:0] == s[7:1]))));
		end
		results();
	end
endmodule : test_icr_regs
